/* verilog/via_pkg.sv */
// package: constants for the vectored interrupt arbiter
package via_pkg;
   localparam int NUM_SRC = 20;
   localparam int NUM_EXT = 6;
   localparam int NUM_INT = 14;
   localparam int RANK_W  = 5;
   localparam int VEC_W   = 16;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 12;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_REQ    = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_PRIO   = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_VECTOR = 12'h014;

   // reset values
   localparam logic [NUM_SRC-1:0] MASK_RST = 20'hFFFFF;
   localparam logic [NUM_SRC-1:0] PRIO_RST = 20'hFFFFF;
   localparam logic [NUM_SRC-1:0] REQ_RST  = 20'h00000;

   // control fields
   localparam int CTRL_IE_BIT     = 0;
   localparam int CTRL_LVMODE_BIT = 1;
   localparam int CTRL_CARRIER_BIT = 2;

   // status fields
   localparam int ST_PEND_BIT  = 0;
   localparam int ST_HIGH_BIT  = 1;
   localparam int ST_NEST_BIT  = 2;
   localparam int ST_RANK_LSB  = 8;

   // source ranks
   localparam int RK_LVI   = 0;
   localparam int RK_PIN0  = 1;
   localparam int RK_SBERR = 7;
   localparam int RK_SBRX  = 8;
   localparam int RK_SBTX  = 9;
   localparam int RK_CSTX  = 10;
   localparam int RK_HT1   = 11;
   localparam int RK_HT0   = 12;
   localparam int RK_BTA   = 13;
   localparam int RK_WCA   = 14;
   localparam int RK_WCB   = 15;
   localparam int RK_AD    = 16;
   localparam int RK_SARX  = 17;
   localparam int RK_BTB   = 18;
   localparam int RK_IIC   = 19;

   localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
   localparam logic [VEC_W-1:0] VEC_BREAK = 16'h003E;

   // vector table per rank
   function automatic logic [VEC_W-1:0] via_vector(input logic [RANK_W-1:0] rk);
      logic [VEC_W-1:0] v;
      v = 16'h0000;
      unique case (rk)
         5'h00: v = 16'h0004;
         5'h01: v = 16'h0006;
         5'h02: v = 16'h0008;
         5'h03: v = 16'h000A;
         5'h04: v = 16'h000C;
         5'h05: v = 16'h000E;
         5'h06: v = 16'h0010;
         5'h07: v = 16'h0012;
         5'h08: v = 16'h0014;
         5'h09: v = 16'h0016;
         5'h0A: v = 16'h0018;
         5'h0B: v = 16'h001A;
         5'h0C: v = 16'h001C;
         5'h0D: v = 16'h001E;
         5'h0E: v = 16'h0020;
         5'h0F: v = 16'h0022;
         5'h10: v = 16'h0024;
         5'h11: v = 16'h0026;
         5'h12: v = 16'h002A;
         5'h13: v = 16'h0034;
         default: v = VEC_RESET;
      endcase
      return v;
   endfunction

   typedef enum logic [1:0] {
      VIA_IDLE,
      VIA_OFFER,
      VIA_SERVE
   } via_state_t;
endpackage

/* verilog/via_arbiter.sv */
// vectored interrupt arbiter with apb register access
//
// Functional notes
// - priority bit picks high or low group
// - high request nests over low service
// - equal group resolved by rank 0..19
// - unmasked request raises standby release
// - six pin and fourteen internal sources
// - break taken even when disabled
// - break ignores priority, vector 003EH
// - pins ranks 1..6, vectors 0006H..0010H
// - low voltage rank 0 when mode clear
// - low voltage resets when mode set
// - serial b error, rx, tx ranks 7..9
// - clocked serial or tx a share rank 10
// - h timers and timer a ranks 11..13
// - wide channel a rank 14, 0020H
// - wide channel b rank 15, 0022H
// - conversion done rank 16, 0024H
// - serial a rx or error rank 17
// - timer b or carrier on rank 18
// - two wire done rank 19, 0034H
// - all resets use start vector
// - flag sets on event, clears on ack
// - shared bit set by either source
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module via_arbiter
   import via_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [DATA_W-1:0]    pwdata,
   output logic [DATA_W-1:0]         prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [NUM_EXT-1:0]   pin_edge_irq_0_to_5,
   input  wire logic                 low_voltage_irq,
   input  wire logic                 serial_b_rx_error_irq,
   input  wire logic                 serial_b_rx_done_irq,
   input  wire logic                 serial_b_tx_done_irq,
   input  wire logic                 clocked_serial_done_irq,
   input  wire logic                 serial_a_tx_done_irq,
   input  wire logic                 h_timer_one_match_irq,
   input  wire logic                 h_timer_zero_match_irq,
   input  wire logic                 byte_timer_a_match_irq,
   input  wire logic                 wide_timer_ch_a_irq,
   input  wire logic                 wide_timer_ch_b_irq,
   input  wire logic                 conversion_done_irq,
   input  wire logic                 serial_a_rx_irq,
   input  wire logic                 byte_timer_b_match_irq,
   input  wire logic                 carrier_timer_irq,
   input  wire logic                 two_wire_done_irq,
   input  wire logic                 software_break_instruction,
   input  wire logic                 reset_pin_req,
   input  wire logic                 power_on_clear,
   input  wire logic                 watchdog_overflow_reset,
   input  wire logic                 cpu_ack,
   input  wire logic                 cpu_reti,
   output logic                      irq_req,
   output logic [VEC_W-1:0]          irq_vector,
   output logic                      standby_release,
   output logic                      reset_req
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [NUM_EXT-1:0] pin_s1_r;
   logic [NUM_EXT-1:0] pin_s2_r;
   logic [NUM_EXT-1:0] pin_s3_r;
   logic [NUM_EXT-1:0] pin_rise;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
      end else begin
         pin_s1_r <= pin_edge_irq_0_to_5;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [NUM_SRC-1:0] req_r;
   logic [NUM_SRC-1:0] mask_r;
   logic [NUM_SRC-1:0] prio_r;
   logic               ie_r;
   logic               lv_mode_r;
   logic               carrier_r;
   logic [NUM_SRC-1:0] event_v;
   logic [NUM_SRC-1:0] req_nxt;
   logic               wr_en;
   logic               rd_en;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // ----------------------------------------
   // source events
   // ----------------------------------------
   always_comb begin
      event_v = '0;
      event_v[RK_PIN0 +: NUM_EXT] = pin_rise;
      event_v[RK_LVI] = low_voltage_irq && !lv_mode_r;
      event_v[RK_SBERR] = serial_b_rx_error_irq;
      event_v[RK_SBRX]  = serial_b_rx_done_irq;
      event_v[RK_SBTX]  = serial_b_tx_done_irq;
      event_v[RK_CSTX]  = clocked_serial_done_irq || serial_a_tx_done_irq;
      event_v[RK_HT1]   = h_timer_one_match_irq;
      event_v[RK_HT0]   = h_timer_zero_match_irq;
      event_v[RK_BTA]   = byte_timer_a_match_irq;
      event_v[RK_WCA]   = wide_timer_ch_a_irq;
      event_v[RK_WCB]   = wide_timer_ch_b_irq;
      event_v[RK_AD]    = conversion_done_irq;
      event_v[RK_SARX]  = serial_a_rx_irq;
      event_v[RK_BTB]   = carrier_r ? carrier_timer_irq : byte_timer_b_match_irq;
      event_v[RK_IIC]   = two_wire_done_irq;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_pin
         assign pin_rise[gi] = pin_s2_r[gi] && !pin_s3_r[gi];
      end
   endgenerate

   // ----------------------------------------
   // arbitration
   // ----------------------------------------
   logic [NUM_SRC-1:0] elig;
   logic [NUM_SRC-1:0] elig_hi;
   logic               win_vld;
   logic               win_hi;
   logic [RANK_W-1:0]  win_rank;
   logic               isp_hi_r;
   logic               isp_lo_r;
   via_state_t         state_r;
   logic [RANK_W-1:0]  sel_rank_r;
   logic               sel_hi_r;
   logic               sel_brk_r;

   function automatic logic [RANK_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [RANK_W-1:0] r;
      r = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = RANK_W'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      elig = req_r & ~mask_r & {NUM_SRC{ie_r}};
      elig_hi = elig & ~prio_r;
      win_hi  = |elig_hi;
      win_vld = win_hi ? !isp_hi_r : ((|elig) && !isp_hi_r && !isp_lo_r);
      win_rank = win_hi ? first_set(elig_hi) : first_set(elig);
   end

   // clear on acknowledge of the offered source
   logic [NUM_SRC-1:0] clr_v;
   always_comb begin
      clr_v = '0;
      if (state_r == VIA_OFFER && cpu_ack && !sel_brk_r) begin
         clr_v[sel_rank_r] = 1'b1;
      end
   end

   always_comb begin
      req_nxt = req_r & ~clr_v;
      if (wr_en && paddr == OFS_REQ) begin
         req_nxt = pwdata[NUM_SRC-1:0];
      end
      req_nxt = req_nxt | event_v;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_r <= REQ_RST;
      end else begin
         req_r <= req_nxt;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_r    <= MASK_RST;
         prio_r    <= PRIO_RST;
         ie_r      <= 1'b0;
         lv_mode_r <= 1'b0;
         carrier_r <= 1'b0;
      end else if (wr_en) begin
         if (paddr == OFS_MASK) begin
            mask_r <= pwdata[NUM_SRC-1:0];
         end
         if (paddr == OFS_PRIO) begin
            prio_r <= pwdata[NUM_SRC-1:0];
         end
         if (paddr == OFS_CTRL) begin
            ie_r      <= pwdata[CTRL_IE_BIT];
            lv_mode_r <= pwdata[CTRL_LVMODE_BIT];
            carrier_r <= pwdata[CTRL_CARRIER_BIT];
         end
      end
   end

   // ----------------------------------------
   // offer and service state
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r    <= VIA_IDLE;
         sel_rank_r <= '0;
         sel_hi_r   <= 1'b0;
         sel_brk_r  <= 1'b0;
         irq_req    <= 1'b0;
         irq_vector <= VEC_RESET;
         isp_hi_r   <= 1'b0;
         isp_lo_r   <= 1'b0;
      end else begin
         unique case (state_r)
            VIA_IDLE, VIA_SERVE: begin
               if (cpu_reti) begin
                  if (isp_hi_r) begin
                     isp_hi_r <= 1'b0;
                  end else begin
                     isp_lo_r <= 1'b0;
                  end
               end
               if (software_break_instruction) begin
                  state_r    <= VIA_OFFER;
                  sel_brk_r  <= 1'b1;
                  irq_req    <= 1'b1;
                  irq_vector <= VEC_BREAK;
               end else if (win_vld && !cpu_reti) begin
                  state_r    <= VIA_OFFER;
                  sel_brk_r  <= 1'b0;
                  sel_rank_r <= win_rank;
                  sel_hi_r   <= win_hi;
                  irq_req    <= 1'b1;
                  irq_vector <= via_vector(win_rank);
               end
            end
            VIA_OFFER: begin
               if (cpu_ack) begin
                  irq_req <= 1'b0;
                  state_r <= VIA_SERVE;
                  if (!sel_brk_r) begin
                     if (sel_hi_r) begin
                        isp_hi_r <= 1'b1;
                     end else begin
                        isp_lo_r <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // standby and reset outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         standby_release <= 1'b0;
         reset_req       <= 1'b0;
      end else begin
         standby_release <= |(req_r & ~mask_r);
         reset_req <= (low_voltage_irq && lv_mode_r) || reset_pin_req
                      || power_on_clear || watchdog_overflow_reset;
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               OFS_REQ:    prdata <= DATA_W'(req_r);
               OFS_MASK:   prdata <= DATA_W'(mask_r);
               OFS_PRIO:   prdata <= DATA_W'(prio_r);
               OFS_CTRL:   prdata <= DATA_W'({carrier_r, lv_mode_r, ie_r});
               OFS_STATUS: prdata <= DATA_W'({win_rank, 5'h00, isp_lo_r, isp_hi_r, irq_req});
               OFS_VECTOR: prdata <= DATA_W'(irq_vector);
               default:    prdata <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_req_clr;
      @(posedge clk_sys) disable iff (rst)
      (state_r == VIA_OFFER && cpu_ack && !sel_brk_r && !event_v[sel_rank_r]
       && !(wr_en && paddr == OFS_REQ))
      |=> !req_r[$past(sel_rank_r)];
   endproperty
   a_req_clr: assert property (p_req_clr) else $error("flag not cleared on ack");

   property p_brk_vec;
      @(posedge clk_sys) disable iff (rst)
      (state_r != VIA_OFFER && software_break_instruction) |=> irq_req && irq_vector == VEC_BREAK;
   endproperty
   a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");

   property p_mask_gate;
      @(posedge clk_sys) disable iff (rst)
      (state_r != VIA_OFFER && !software_break_instruction && !ie_r) |=> !irq_req;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("offer while disabled");

   property p_nest;
      @(posedge clk_sys) disable iff (rst)
      (state_r == VIA_SERVE && isp_lo_r && !isp_hi_r && win_hi && !cpu_reti
       && !software_break_instruction) |=> irq_req && sel_hi_r;
   endproperty
   a_nest: assert property (p_nest) else $error("high not nested");

   property p_shared;
      @(posedge clk_sys) disable iff (rst)
      serial_a_tx_done_irq |=> req_r[RK_CSTX];
   endproperty
   a_shared: assert property (p_shared) else $error("shared bit not set");

   property p_lvreset;
      @(posedge clk_sys) disable iff (rst)
      (low_voltage_irq && lv_mode_r) |-> !event_v[RK_LVI] ##1 reset_req;
   endproperty
   a_lvreset: assert property (p_lvreset) else $error("lv reset missing");

   property p_pin;
      @(posedge clk_sys) disable iff (rst)
      $rose(pin_s2_r[0]) |=> req_r[RK_PIN0];
   endproperty
   a_pin: assert property (p_pin) else $error("pin edge lost");

   property p_wake;
      @(posedge clk_sys) disable iff (rst)
      (req_r[RK_AD] && !mask_r[RK_AD]) |=> standby_release;
   endproperty
   a_wake: assert property (p_wake) else $error("no standby release");

   c_brk:  cover property (@(posedge clk_sys) disable iff (rst) software_break_instruction ##1 irq_req);
   c_nest: cover property (@(posedge clk_sys) disable iff (rst) isp_lo_r && isp_hi_r);
   c_ack:  cover property (@(posedge clk_sys) disable iff (rst) irq_req && cpu_ack);

endmodule
`default_nettype wire

/* dv/via_cpu_model.sv */
// core model: takes offered vectors and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module via_cpu_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic        auto_ret,
   input  wire logic        ret_now,
   output logic             cpu_ack,
   output logic             cpu_reti,
   output logic [15:0]      last_vec,
   output logic [7:0]       n_taken,
   output logic [1:0]       depth
);
   logic [2:0] run_r;
   // ------------------------------
   // fetch and return
   // ------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cpu_ack  <= 1'b0;
         cpu_reti <= 1'b0;
         last_vec <= 16'h0000;
         n_taken  <= 8'h00;
         depth    <= 2'h0;
         run_r    <= 3'h0;
      end else begin
         cpu_ack  <= 1'b0;
         cpu_reti <= 1'b0;
         if (irq_req && !cpu_ack) begin
            cpu_ack  <= 1'b1;
            last_vec <= irq_vector;
            n_taken  <= n_taken + 8'h01;
            depth    <= depth + 2'h1;
            run_r    <= 3'h0;
         end else if (depth != 2'h0 && !cpu_reti && (ret_now || (auto_ret && run_r == 3'h5))) begin
            cpu_reti <= 1'b1;
            depth    <= depth - 2'h1;
            run_r    <= 3'h0;
         end else begin
            run_r <= run_r + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/via_arbiter_bench.sv */
// self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module via_arbiter_bench;
   import via_pkg::*;
   logic               clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic               irq_req, standby_release, reset_req, auto_ret, ret_now;
   logic               cpu_ack, cpu_reti;
   logic [ADDR_W-1:0]  paddr;
   logic [DATA_W-1:0]  pwdata, prdata, rd;
   logic [NUM_SRC-1:0] src;
   logic [2:0]         aux, rsrc;
   logic [VEC_W-1:0]   irq_vector, last_vec;
   logic [7:0]         n_taken, nt0;
   logic [1:0]         depth;
   int                 n_errors, checks_done, cyc;
   logic [15:0] vt [20] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
      16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E,
      16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h002A, 16'h0034};

   via_arbiter uut (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .pin_edge_irq_0_to_5(src[6:1]), .low_voltage_irq(src[0]),
      .serial_b_rx_error_irq(src[7]), .serial_b_rx_done_irq(src[8]),
      .serial_b_tx_done_irq(src[9]), .clocked_serial_done_irq(src[10]),
      .serial_a_tx_done_irq(aux[0]), .h_timer_one_match_irq(src[11]),
      .h_timer_zero_match_irq(src[12]), .byte_timer_a_match_irq(src[13]),
      .wide_timer_ch_a_irq(src[14]), .wide_timer_ch_b_irq(src[15]),
      .conversion_done_irq(src[16]), .serial_a_rx_irq(src[17]),
      .byte_timer_b_match_irq(src[18]), .carrier_timer_irq(aux[1]),
      .two_wire_done_irq(src[19]), .software_break_instruction(aux[2]),
      .reset_pin_req(rsrc[0]), .power_on_clear(rsrc[1]), .watchdog_overflow_reset(rsrc[2]),
      .cpu_ack, .cpu_reti, .irq_req, .irq_vector, .standby_release, .reset_req);

   via_cpu_model cpu (.clk_sys, .rst, .irq_req, .irq_vector, .auto_ret, .ret_now,
      .cpu_ack, .cpu_reti, .last_vec, .n_taken, .depth);

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ------------------------------
   // bus and stimulus tasks
   // ------------------------------
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %0h", a), e, rd)
   endtask
   task automatic fire(input logic [NUM_SRC-1:0] m, input logic [2:0] x);
      @(posedge clk_sys);
      src <= m;
      aux <= x;
      @(posedge clk_sys);
      src <= '0;
      aux <= '0;
   endtask
   task automatic take(input logic [15:0] e);
      int n;
      n = 0;
      while (n_taken === nt0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 100) begin
         n_errors++;
      end
      nt0 = n_taken;
      `CHK("vector", e, last_vec)
   endtask
   task automatic idle();
      int n;
      n = 0;
      while ((depth !== 2'h0 || irq_req !== 1'b0) && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 100) begin
         n_errors++;
      end
   endtask
   task automatic cyc_wait(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic ret();
      @(posedge clk_sys);
      ret_now <= 1'b1;
      @(posedge clk_sys);
      ret_now <= 1'b0;
      cyc_wait(2);
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      {rst, auto_ret} = 2'b11;
      {psel, penable, pwrite, ret_now} = '0;
      {paddr, pwdata, src, aux, rsrc} = '0;
      {n_errors, checks_done, cyc} = '0;
      nt0 = 8'h00;
      cyc_wait(10);
      rst <= 1'b0;
      rchk(OFS_MASK, 32'h000FFFFF);
      rchk(OFS_PRIO, 32'h000FFFFF);
      rchk(OFS_CTRL, 32'h0);
      wr(12'h040, 32'hFFFFFFFF);
      rchk(12'h040, 32'h0);
      wr(OFS_CTRL, 32'h1);
      for (int r = 0; r < NUM_SRC; r++) begin
         wr(OFS_MASK, ~(32'h1 << r));
         fire(20'h1 << r, 3'h0);
         take(vt[r]);
         rchk(OFS_REQ, 32'h0);
         idle();
      end
      wr(OFS_MASK, ~(32'h1 << 10));
      fire('0, 3'h1);
      take(16'h0018);
      idle();
      wr(OFS_CTRL, 32'h5);
      wr(OFS_MASK, ~(32'h1 << 18));
      fire(20'h1 << 18, 3'h0);
      rchk(OFS_REQ, 32'h0);
      fire('0, 3'h2);
      take(16'h002A);
      idle();
      wr(OFS_CTRL, 32'h1);
      wr(OFS_MASK, 32'h0);
      fire(20'h10100, 3'h0);
      take(16'h0014);
      take(16'h0024);
      idle();
      wr(OFS_PRIO, ~(32'h1 << 19));
      fire(20'h80001, 3'h0);
      take(16'h0034);
      take(16'h0004);
      idle();
      auto_ret <= 1'b0;
      wr(OFS_PRIO, ~(32'h1 << 11));
      fire(20'h1 << 16, 3'h0);
      take(16'h0024);
      fire(20'h1 << 17, 3'h0);
      cyc_wait(20);
      `CHK("low nest", nt0, n_taken)
      fire(20'h1 << 11, 3'h0);
      take(16'h001A);
      rchk(OFS_STATUS, 32'h00001106);
      rchk(OFS_VECTOR, 32'h0000001A);
      ret();
      ret();
      take(16'h0026);
      auto_ret <= 1'b1;
      idle();
      wr(OFS_CTRL, 32'h0);
      fire('0, 3'h4);
      take(16'h003E);
      idle();
      wr(OFS_MASK, ~(32'h1 << 13));
      fire(20'h1 << 13, 3'h0);
      cyc_wait(3);
      `CHK("standby", 1'b1, standby_release)
      `CHK("irq_req", 1'b0, irq_req)
      wr(OFS_MASK, 32'hFFFFF);
      cyc_wait(2);
      `CHK("standby", 1'b0, standby_release)
      wr(OFS_REQ, 32'h0);
      wr(OFS_CTRL, 32'h3);
      wr(OFS_MASK, 32'h0);
      @(posedge clk_sys);
      src <= 20'h1;
      cyc_wait(3);
      `CHK("reset_req", 1'b1, reset_req)
      rchk(OFS_REQ, 32'h0);
      src <= '0;
      for (int i = 0; i < 3; i++) begin
         cyc_wait(3);
         rsrc <= 3'h1 << i;
         cyc_wait(3);
         `CHK("reset_req", 1'b1, reset_req)
         rsrc <= 3'h0;
      end
      cyc_wait(3);
      `CHK("reset_req", 1'b0, reset_req)
      finish_test();
   end
endmodule
`default_nettype wire
